// ### hw/csb_bank_ram.sv
/*
  Banked register RAM: one byte-enabled write port, two registered read ports.
  Assumes the caller never needs a write and a read of one word to bypass.
*/
`timescale 1ns/1ns
module csb_bank_ram #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [DW/8-1:0] i_wr_be,
  input wire logic [DW-1:0] i_wr_data,
  // Read ports, data one cycle after the address
  input wire logic [AW-1:0] i_rd_addr_a,
  input wire logic [AW-1:0] i_rd_addr_b,
  output logic [DW-1:0] o_rd_data_a,
  output logic [DW-1:0] o_rd_data_b
);

  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd_a;
    logic [DW-1:0] rd_b;
  } csb_ram_s;

  csb_ram_s s_q;
  csb_ram_s s_d;

  // Reads see the old word when written in the same cycle
  always_comb begin
    s_d = s_q;
    s_d.rd_a = s_q.mem[i_rd_addr_a];
    s_d.rd_b = s_q.mem[i_rd_addr_b];
    for (int k = 0; k < DW / 8; k++) begin
      if (i_wr_en && i_wr_be[k]) begin
        s_d.mem[i_wr_addr][k*8 +: 8] = i_wr_data[k*8 +: 8];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rd_data_a = s_q.rd_a;
  assign o_rd_data_b = s_q.rd_b;

endmodule : csb_bank_ram

// ### hw/csb_core.sv
/*
  Stack pointer, status word and eight banks of general registers of the CPU.
  Assumes the instruction sequencer drives every input from the same clock.
*/
// Contract
// - Stack pointer is a 24-bit register addressing the stack.
// - Pointer decrements before a stack write, increments after a read.
// - Non-maskable interrupts are taken even with an unloaded stack pointer.
// - Sixteen byte registers per bank, adjacent pairs form 16-bit registers.
// - Four pairs plus own extension bytes form 24-bit pointers.
// - Registers live in RAM as eight banks, switchable.
// - Reset selects bank 0; status word shows the active bank.
// - Bank storage answers data accesses at 0FE80H to 0FEFFH.
// - Alternate location moves the bank window up by 0F0000H.
// - Swap bit maps function names onto R4 to R7 and pairs 2, 3.
// - Interrupt pushes the status word; returns restore it.
// - Context switch saves low 16 program counter bits in pair 2.
// - Pair 3 gets counter top bits and status word minus bits 8-11.
// - B and C are decrement-and-branch loop counters.
// - C counts string elements; T and W pointers address strings.
// - Accumulator pair with index pair D forms a 32-bit operand.
// - Pointer U serves as a separate user stack pointer.
// - Pairs D and H supply index offsets.
// - Three bank bits encode the bank as binary 0 to 7.
`timescale 1ns/1ns
module csb_core (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Sequencer command port
  input wire logic i_cmd_valid,
  input wire csb_pkg::csb_cmd_e i_cmd,
  input wire logic [3:0] i_cmd_sel,
  input wire logic i_cmd_func,
  input wire logic [31:0] i_cmd_data,
  input wire logic [19:0] i_mem_addr,
  input wire logic [19:0] i_pc,
  input wire logic i_location_high,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_data,
  output logic o_rsp_nonzero,
  output logic o_rsp_miss,
  // Status word
  input wire logic i_psw_we,
  input wire logic [15:0] i_psw_wdata,
  input wire logic i_int_ack,
  input wire logic i_int_ret,
  input wire logic [15:0] i_ret_psw,
  output logic [15:0] o_program_status_word,
  output logic [2:0] o_bank,
  // Stack pointer
  input wire logic i_sp_load,
  input wire logic [23:0] i_sp_wdata,
  input wire logic i_sp_push,
  input wire logic i_sp_pop,
  input wire logic [2:0] i_sp_bytes,
  output logic [23:0] o_stack_top_pointer,
  output logic o_sp_loaded
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SECOND} csb_state_e;

  typedef struct packed {
    csb_state_e st;
    csb_pkg::csb_cmd_e cmd;
    logic hi_lane;
    logic [5:0] word;
    logic [1:0] ext;
    logic [15:0] hold;
    logic [15:0] program_status_word;
    logic [23:0] sp;
    logic sp_loaded;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic rsp_nz;
    logic rsp_miss;
  } csb_core_s;

  csb_core_s s_q;
  csb_core_s s_d;

  // RAM and extension register hookup
  logic ram_we;
  logic [5:0] ram_waddr;
  logic [1:0] ram_be;
  logic [15:0] ram_wdata;
  logic [5:0] ram_ra;
  logic [5:0] ram_rb;
  logic [15:0] ram_qa;
  logic [15:0] ram_qb;
  logic [3:0] ext_we;
  logic [7:0] ext_wdata;
  logic [3:0][7:0] ext_q;

  // Decoded command fields
  logic [2:0] bank;
  logic swap;
  logic [3:0] bidx;
  logic [2:0] pidx;
  logic [19:0] win_base;
  logic [19:0] win_off;
  logic win_hit;
  logic [7:0] lane_byte;
  logic [7:0] dec_byte;

  // Word address of a pair in a bank; bank 7 sits lowest
  function automatic logic [5:0] word_of(input logic [2:0] bk, input logic [2:0] pr);
    return {~bk, pr};
  endfunction : word_of

  // Function names X, A, C, B move to R4 to R7 under the swap bit
  function automatic logic [3:0] map_byte(input logic [3:0] idx, input logic fn,
                                          input logic sw);
    return (fn && sw && idx < 4'h4) ? idx + csb_pkg::SWAP_STEP_BYTE : idx;
  endfunction : map_byte

  function automatic logic [2:0] map_pair(input logic [2:0] pr, input logic fn,
                                          input logic sw);
    return (fn && sw && pr < 3'h2) ? pr + csb_pkg::SWAP_STEP_PAIR : pr;
  endfunction : map_pair

  // Field decode shared by the command process and the checks
  assign bank = s_q.program_status_word[csb_pkg::PSW_BANK_LSB +: 3];
  assign swap = s_q.program_status_word[csb_pkg::PSW_SWAP_BIT];
  assign bidx = map_byte(i_cmd_sel, i_cmd_func, swap);
  assign pidx = map_pair(i_cmd_sel[2:0], i_cmd_func, swap);
  assign win_base = i_location_high ? csb_pkg::BANK_BASE + csb_pkg::ALT_OFFSET
                                    : csb_pkg::BANK_BASE;
  assign win_off = i_mem_addr - win_base;
  assign win_hit = win_off <= (csb_pkg::BANK_LAST - csb_pkg::BANK_BASE);
  assign lane_byte = s_q.hi_lane ? ram_qa[15:8] : ram_qa[7:0];
  assign dec_byte = lane_byte - 8'h01;

  // Next state: stack pointer, status word and the command sequencer
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'h0;
    ram_we = 1'h0;
    ram_waddr = 6'h00;
    ram_be = 2'h0;
    ram_wdata = 16'h0000;
    ram_ra = 6'h00;
    ram_rb = 6'h00;
    ext_we = 4'h0;
    ext_wdata = i_cmd_data[23:16];
    // Pointer moves before a push and after a pop; no gating by load state
    if (i_sp_load) begin
      s_d.sp = i_sp_wdata;
      s_d.sp_loaded = 1'h1;
    end else if (i_int_ack) begin
      s_d.sp = s_q.sp - csb_pkg::PSW_FRAME;
    end else if (i_sp_push) begin
      s_d.sp = s_q.sp - {21'h000000, i_sp_bytes};
    end else if (i_int_ret) begin
      s_d.sp = s_q.sp + csb_pkg::PSW_FRAME;
    end else if (i_sp_pop) begin
      s_d.sp = s_q.sp + {21'h000000, i_sp_bytes};
    end
    // Status word restore on return wins over a plain write
    if (i_int_ret) begin
      s_d.program_status_word = i_ret_psw;
    end else if (i_psw_we) begin
      s_d.program_status_word = i_psw_wdata;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (i_cmd_valid) begin
          s_d.cmd = i_cmd;
          s_d.rsp_miss = 1'h0;
          s_d.rsp_nz = 1'h0;
          unique case (i_cmd)
            csb_pkg::CMD_RD8: begin
              ram_ra = word_of(bank, bidx[3:1]);
              s_d.hi_lane = bidx[0];
              s_d.st = ST_WAIT;
            end
            csb_pkg::CMD_WR8: begin
              ram_we = 1'h1;
              ram_waddr = word_of(bank, bidx[3:1]);
              ram_be = bidx[0] ? 2'h2 : 2'h1;
              ram_wdata = {2{i_cmd_data[7:0]}};
              s_d.rsp_valid = 1'h1;
              s_d.rsp_data = 32'h00000000;
            end
            csb_pkg::CMD_RD16: begin
              ram_ra = word_of(bank, pidx);
              s_d.st = ST_WAIT;
            end
            csb_pkg::CMD_WR16: begin
              ram_we = 1'h1;
              ram_waddr = word_of(bank, pidx);
              ram_be = 2'h3;
              ram_wdata = i_cmd_data[15:0];
              s_d.rsp_valid = 1'h1;
              s_d.rsp_data = 32'h00000000;
            end
            csb_pkg::CMD_RD24: begin
              ram_ra = word_of(bank, csb_pkg::PAIR_PTR_BASE | {1'h0, i_cmd_sel[1:0]});
              s_d.ext = i_cmd_sel[1:0];
              s_d.st = ST_WAIT;
            end
            csb_pkg::CMD_WR24: begin
              ram_we = 1'h1;
              ram_waddr = word_of(bank, csb_pkg::PAIR_PTR_BASE | {1'h0, i_cmd_sel[1:0]});
              ram_be = 2'h3;
              ram_wdata = i_cmd_data[15:0];
              ext_we[i_cmd_sel[1:0]] = 1'h1;
              s_d.rsp_valid = 1'h1;
              s_d.rsp_data = 32'h00000000;
            end
            csb_pkg::CMD_RD32: begin
              ram_ra = word_of(bank, map_pair(csb_pkg::PAIR_AX, 1'h1, swap));
              ram_rb = word_of(bank, csb_pkg::PAIR_DE);
              s_d.st = ST_WAIT;
            end
            csb_pkg::CMD_WR32: begin
              // Only one write port, so the low half goes in the next cycle
              ram_we = 1'h1;
              ram_waddr = word_of(bank, map_pair(csb_pkg::PAIR_AX, 1'h1, swap));
              ram_be = 2'h3;
              ram_wdata = i_cmd_data[31:16];
              s_d.word = word_of(bank, csb_pkg::PAIR_DE);
              s_d.hold = i_cmd_data[15:0];
              s_d.st = ST_SECOND;
            end
            csb_pkg::CMD_MRD: begin
              if (win_hit) begin
                ram_ra = win_off[6:1];
                s_d.hi_lane = win_off[0];
                s_d.st = ST_WAIT;
              end else begin
                s_d.rsp_valid = 1'h1;
                s_d.rsp_miss = 1'h1;
                s_d.rsp_data = 32'h00000000;
              end
            end
            csb_pkg::CMD_MWR: begin
              ram_we = win_hit;
              ram_waddr = win_off[6:1];
              ram_be = win_off[0] ? 2'h2 : 2'h1;
              ram_wdata = {2{i_cmd_data[7:0]}};
              s_d.rsp_valid = 1'h1;
              s_d.rsp_miss = !win_hit;
              s_d.rsp_data = 32'h00000000;
            end
            csb_pkg::CMD_DECREMENT_BRANCH_NONZERO: begin
              // Select 0 counts C (low byte), select 1 counts B (high byte)
              ram_ra = word_of(bank, map_pair(csb_pkg::PAIR_BC, 1'h1, swap));
              s_d.word = ram_ra;
              s_d.hi_lane = i_cmd_sel[0];
              s_d.st = ST_WAIT;
            end
            csb_pkg::CMD_CTX: begin
              // Save slots belong to the new bank; the old status word is kept
              s_d.program_status_word[csb_pkg::PSW_BANK_LSB +: 3] = i_cmd_sel[2:0];
              ram_we = 1'h1;
              ram_waddr = word_of(i_cmd_sel[2:0], csb_pkg::PAIR_CTX_LO);
              ram_be = 2'h3;
              ram_wdata = i_pc[15:0];
              s_d.word = word_of(i_cmd_sel[2:0], csb_pkg::PAIR_CTX_HI);
              s_d.hold = {s_q.program_status_word[15:12], i_pc[19:16], s_q.program_status_word[7:0]};
              s_d.st = ST_SECOND;
            end
            default: begin
              s_d.rsp_valid = 1'h1;
              s_d.rsp_miss = 1'h1;
              s_d.rsp_data = 32'h00000000;
            end
          endcase
        end
      end
      ST_WAIT: begin
        s_d.st = ST_IDLE;
        s_d.rsp_valid = 1'h1;
        unique case (s_q.cmd)
          csb_pkg::CMD_RD16: s_d.rsp_data = {16'h0000, ram_qa};
          csb_pkg::CMD_RD24: s_d.rsp_data = {8'h00, ext_q[s_q.ext], ram_qa};
          csb_pkg::CMD_RD32: s_d.rsp_data = {ram_qa, ram_qb};
          csb_pkg::CMD_DECREMENT_BRANCH_NONZERO: begin
            ram_we = 1'h1;
            ram_waddr = s_q.word;
            ram_be = s_q.hi_lane ? 2'h2 : 2'h1;
            ram_wdata = {2{dec_byte}};
            s_d.rsp_data = {24'h000000, dec_byte};
            s_d.rsp_nz = dec_byte != 8'h00;
          end
          default: s_d.rsp_data = {24'h000000, lane_byte};
        endcase
      end
      ST_SECOND: begin
        ram_we = 1'h1;
        ram_waddr = s_q.word;
        ram_be = 2'h3;
        ram_wdata = s_q.hold;
        s_d.st = ST_IDLE;
        s_d.rsp_valid = 1'h1;
        s_d.rsp_data = 32'h00000000;
      end
    endcase
  end

  // State register; reset selects bank 0 and clears the pointer
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.program_status_word <= csb_pkg::PSW_RST;
      s_q.sp <= csb_pkg::SP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Register RAM holding all eight banks
  csb_bank_ram #(
    .AW(csb_pkg::WORD_AW),
    .DW(16)
  ) u_ram (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_wr_en(ram_we),
    .i_wr_addr(ram_waddr),
    .i_wr_be(ram_be),
    .i_wr_data(ram_wdata),
    .i_rd_addr_a(ram_ra),
    .i_rd_addr_b(ram_rb),
    .o_rd_data_a(ram_qa),
    .o_rd_data_b(ram_qb)
  );

  // Extension bytes of the four pointers, outside the banks
  for (genvar g = 0; g < 4; g++) begin : g_ext
    csb_ext_reg #(
      .W(8)
    ) u_ext (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_we(ext_we[g]),
      .i_wdata(ext_wdata),
      .o_q(ext_q[g])
    );
  end

  // Outputs
  assign o_cmd_ready = s_q.st == ST_IDLE;
  assign o_rsp_valid = s_q.rsp_valid;
  assign o_rsp_data = s_q.rsp_data;
  assign o_rsp_nonzero = s_q.rsp_nz;
  assign o_rsp_miss = s_q.rsp_miss;
  assign o_program_status_word = s_q.program_status_word;
  assign o_bank = bank;
  assign o_stack_top_pointer = s_q.sp;
  assign o_sp_loaded = s_q.sp_loaded;

  // Checks
  logic take;
  assign take = i_cmd_valid && o_cmd_ready;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sp_push_a: assert property (
    i_sp_push && !i_sp_load && !i_int_ack
    |=> o_stack_top_pointer == $past(o_stack_top_pointer) - {21'h000000, $past(i_sp_bytes)})
    else $error("push did not pre-decrement the stack pointer");

  sp_pop_a: assert property (
    i_sp_pop && !i_sp_load && !i_int_ack && !i_sp_push && !i_int_ret
    |=> o_stack_top_pointer == $past(o_stack_top_pointer) + {21'h000000, $past(i_sp_bytes)})
    else $error("pop did not post-increment the stack pointer");

  nmi_unloaded_a: assert property (
    i_int_ack && !i_sp_load && !o_sp_loaded
    |=> o_stack_top_pointer == $past(o_stack_top_pointer) - csb_pkg::PSW_FRAME)
    else $error("interrupt before pointer load was not stacked");

  psw_restore_a: assert property (
    i_int_ret && !(take && i_cmd == csb_pkg::CMD_CTX)
    |=> o_program_status_word == $past(i_ret_psw))
    else $error("return did not restore the status word");

  ctx_save_a: assert property (
    take && i_cmd == csb_pkg::CMD_CTX
    |-> ram_we && ram_wdata == i_pc[15:0] && ram_waddr == {~i_cmd_sel[2:0], 3'h2}
    ##1 ram_we && ram_waddr == {~$past(i_cmd_sel[2:0]), 3'h3} && o_bank == $past(i_cmd_sel[2:0]))
    else $error("context switch save went wrong");

  ctx_high_a: assert property (
    take && i_cmd == csb_pkg::CMD_CTX
    |=> ram_wdata == {$past(s_q.program_status_word[15:12]), $past(i_pc[19:16]), $past(s_q.program_status_word[7:0])})
    else $error("context high save word is wrong");

  read_lat_a: assert property (
    take && (i_cmd == csb_pkg::CMD_RD8 || i_cmd == csb_pkg::CMD_RD16)
    |=> !o_cmd_ready && !o_rsp_valid ##1 o_rsp_valid && o_cmd_ready)
    else $error("register read answer not two cycles after request");

  bank_addr_a: assert property (
    take && i_cmd == csb_pkg::CMD_RD16 |-> ram_ra == {3'h7 - o_bank, pidx})
    else $error("bank word address is wrong");

  swap_map_a: assert property (
    take && i_cmd == csb_pkg::CMD_RD8 && i_cmd_func && swap && i_cmd_sel == 4'h1
    |-> ram_ra[2:0] == 3'h2)
    else $error("legacy swap did not map A to R5");

  window_a: assert property (
    take && i_cmd == csb_pkg::CMD_MWR && i_location_high && i_mem_addr == csb_pkg::BANK_BASE
    |=> o_rsp_valid && o_rsp_miss)
    else $error("bank window did not move with alternate location");

  decrement_branch_nonzero_nz_a: assert property (
    take && i_cmd == csb_pkg::CMD_DECREMENT_BRANCH_NONZERO
    |=> ##1 o_rsp_valid && o_rsp_nonzero == (o_rsp_data[7:0] != 8'h00))
    else $error("loop counter result flag is wrong");

endmodule : csb_core

// ### hw/csb_ext_reg.sv
/*
  One 8-bit address-extension register of a 24-bit pointer.
  Assumes writes come from logic on the same clock.
*/
`timescale 1ns/1ns
module csb_ext_reg #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Write port
  input wire logic i_we,
  input wire logic [W-1:0] i_wdata,
  // Stored value
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] val;
  } csb_ext_s;

  csb_ext_s s_q;
  csb_ext_s s_d;

  // Load on write, hold otherwise
  always_comb begin
    s_d = s_q;
    if (i_we) begin
      s_d.val = i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= csb_ext_s'(csb_pkg::EXT_RST);
    end else begin
      s_q <= s_d;
    end
  end

  assign o_q = s_q.val;

endmodule : csb_ext_reg

// ### hw/csb_pkg.sv
/*
  Shared constants and command codes of the CPU stack and banked register store.
  Assumes one core clock and a single instruction sequencer as the only client.
*/
package csb_pkg;

  // Geometry of the banked store
  localparam int BANK_COUNT = 8;
  localparam int REG_COUNT = 16;
  localparam int WORD_AW = 6;

  // Data-memory window of the banks, normal and alternate location
  localparam logic [19:0] BANK_BASE = 20'h0fe80;
  localparam logic [19:0] BANK_LAST = 20'h0feff;
  localparam logic [19:0] ALT_OFFSET = 20'hf0000;

  // Values after reset
  localparam logic [15:0] PSW_RST = 16'h0000;
  localparam logic [23:0] SP_RST = 24'h000000;
  localparam logic [7:0] EXT_RST = 8'h00;

  // Status word fields
  localparam int PSW_BANK_LSB = 12;
  localparam int PSW_SWAP_BIT = 5;

  // Bytes that an interrupt acknowledge pushes for the status word
  localparam logic [23:0] PSW_FRAME = 24'h000002;

  // Register pair indices inside a bank
  localparam logic [2:0] PAIR_AX = 3'h0;
  localparam logic [2:0] PAIR_BC = 3'h1;
  localparam logic [2:0] PAIR_CTX_LO = 3'h2;
  localparam logic [2:0] PAIR_CTX_HI = 3'h3;
  localparam logic [2:0] PAIR_PTR_BASE = 3'h4;
  localparam logic [2:0] PAIR_DE = 3'h6;

  // Index step applied by the legacy register swap
  localparam logic [3:0] SWAP_STEP_BYTE = 4'h4;
  localparam logic [2:0] SWAP_STEP_PAIR = 3'h2;

  // Sequencer commands
  typedef enum logic [3:0] {
    CMD_RD8, CMD_WR8, CMD_RD16, CMD_WR16, CMD_RD24, CMD_WR24,
    CMD_RD32, CMD_WR32, CMD_MRD, CMD_MWR, CMD_DECREMENT_BRANCH_NONZERO, CMD_CTX
  } csb_cmd_e;

endpackage : csb_pkg

// ### verif/cpu_stack_and_banked_registers_tb_top.sv
/*
  Self-checking bench of the stack pointer, status word and register banks.
  Assumes csb_core as top and the sequencer model on its command port.
*/
`timescale 1ns/1ns
module cpu_stack_and_banked_registers_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rdy, rv, rnz, rmiss, cv, cf, ld, ack, ret, psh, pop, pwe, loc, sl;
  csb_pkg::csb_cmd_e cc;
  logic [3:0] cs;
  logic [31:0] cd, rd;
  logic [19:0] ca, pc;
  logic [15:0] rpsw, pw, psw_o, p;
  logic [2:0] bytes, bank;
  logic [23:0] spw, sp_o, v;
  logic [7:0] x;
  logic [19:0] ad;
  int num_errors = 0;
  int n_tests = 0;
  int b, seed_v;

  csb_core csb_core_inst (.i_clock(clk), .i_rst_n(rst_n), .i_cmd_valid(cv), .i_cmd(cc),
    .i_cmd_sel(cs), .i_cmd_func(cf), .i_cmd_data(cd), .i_mem_addr(ca), .i_pc(pc),
    .i_location_high(loc), .o_cmd_ready(rdy), .o_rsp_valid(rv), .o_rsp_data(rd),
    .o_rsp_nonzero(rnz), .o_rsp_miss(rmiss), .i_psw_we(pwe), .i_psw_wdata(pw),
    .i_int_ack(ack), .i_int_ret(ret), .i_ret_psw(rpsw), .o_program_status_word(psw_o),
    .o_bank(bank), .i_sp_load(ld), .i_sp_wdata(spw), .i_sp_push(psh), .i_sp_pop(pop),
    .i_sp_bytes(bytes), .o_stack_top_pointer(sp_o), .o_sp_loaded(sl));
  csb_seq_model csb_seq_model_inst (.i_clock(clk), .i_ready(rdy), .i_rsp_valid(rv),
    .i_rsp_data(rd), .i_rsp_nonzero(rnz), .i_rsp_miss(rmiss), .o_valid(cv), .o_cmd(cc),
    .o_sel(cs), .o_func(cf), .o_data(cd), .o_addr(ca), .o_pc(pc));

  // 250 MHz core clock
  always #2 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Byte address of register idx of bank bk in the data window; bank 7 sits lowest
  function automatic logic [19:0] reg_addr(input int bk, input int idx, input logic alt);
    return csb_pkg::BANK_BASE + 20'(16 * (7 - bk) + idx)
           + (alt ? csb_pkg::ALT_OFFSET : 20'h0);
  endfunction : reg_addr

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Pointer pulses in order load, ack, push, return, pop; checked after the edge
  task automatic spo(input logic [4:0] m, input logic [2:0] nb);
    @(posedge clk) #1;
    {ld, ack, psh, ret, pop} = m;
    bytes = nb;
    @(posedge clk) #1;
    {ld, ack, psh, ret, pop} = '0;
  endtask : spo

  task automatic program_status_word(input logic [15:0] w);
    @(posedge clk) #1;
    pwe = 1'b1;
    pw = w;
    @(posedge clk) #1;
    pwe = 1'b0;
  endtask : program_status_word

  // A command whose answer must come within the bound
  task automatic go(input csb_pkg::csb_cmd_e c, input logic [3:0] s, input logic f,
                    input logic [31:0] d, input logic [19:0] a);
    logic ok;
    csb_seq_model_inst.issue(c, s, f, d, a, ok);
    chk("answer", {31'h0, ok}, 32'h1);
  endtask : go

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    num_errors++;
    close_out();
  end

  initial begin
    {ld, ack, psh, ret, pop, pwe, loc} = '0;
    {bytes, spw, pw, rpsw} = '0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    seed_v = $urandom(32'h0fe71bc3);
    chk("bank", bank, 32'h0);
    chk("loaded", sl, 32'h0);
    // Interrupt taken before the pointer is loaded
    spo(5'b01000, 3'h0);
    chk("sp nmi", sp_o, 32'hfffffe);
    v = $urandom();
    v[23:20] = 4'h0;
    // Keep the stack in plain RAM, clear of the special registers and ROM
    v[19:8] = 12'h0fd;
    spw = v;
    spo(5'b10000, 3'h0);
    chk("sp load", sp_o, v);
    chk("loaded", sl, 32'h1);
    spo(5'b00100, 3'h2);
    chk("sp push", sp_o, v - 24'h2);
    rpsw = $urandom();
    spo(5'b00010, 3'h0);
    chk("sp ret", sp_o, v);
    chk("psw ret", psw_o, rpsw);
    spo(5'b00001, 3'h3);
    chk("sp pop", sp_o, v + 24'h3);
    $display("stack test done");
    // Every bank, each at a randomly chosen window location
    for (b = 0; b < 8; b++) begin
      program_status_word(16'(b) << 12);
      chk("bank sel", bank, b);
      loc = 1'($urandom());
      p = $urandom();
      go(csb_pkg::CMD_WR16, 4'h6, 1'b0, {16'h0, p}, '0);
      ad = reg_addr(b, 12, loc);
      go(csb_pkg::CMD_MRD, 4'h0, 1'b0, '0, ad);
      chk("mem lo", csb_seq_model_inst.rsp_q, p[7:0]);
      go(csb_pkg::CMD_MRD, 4'h0, 1'b0, '0, ad + 20'h1);
      chk("mem hi", csb_seq_model_inst.rsp_q, p[15:8]);
      x = $urandom();
      go(csb_pkg::CMD_MWR, 4'h0, 1'b0, {24'h0, x}, ad + 20'h2);
      go(csb_pkg::CMD_RD8, 4'he, 1'b0, '0, '0);
      chk("mem alias", csb_seq_model_inst.rsp_q, x);
    end
    go(csb_pkg::CMD_MRD, 4'h0, 1'b0, '0, csb_pkg::BANK_LAST + 20'h1);
    chk("miss", csb_seq_model_inst.miss_q, 32'h1);
    // Normal-location address must miss once the window has moved up
    loc = 1'b1;
    go(csb_pkg::CMD_MWR, 4'h0, 1'b0, '0, csb_pkg::BANK_BASE);
    chk("alt miss", csb_seq_model_inst.miss_q, 32'h1);
    $display("bank test done");
    // Legacy swap moves A and C to R5 and R6
    program_status_word(16'h0020);
    go(csb_pkg::CMD_WR8, 4'h1, 1'b1, {24'h0, x}, '0);
    go(csb_pkg::CMD_RD8, 4'h5, 1'b0, '0, '0);
    chk("swap A", csb_seq_model_inst.rsp_q, x);
    go(csb_pkg::CMD_RD8, 4'h1, 1'b1, '0, '0);
    chk("swap A fn", csb_seq_model_inst.rsp_q, x);
    go(csb_pkg::CMD_WR8, 4'h2, 1'b1, 32'h1, '0);
    go(csb_pkg::CMD_DECREMENT_BRANCH_NONZERO, 4'h0, 1'b1, '0, '0);
    chk("decrement_branch_nonzero C", csb_seq_model_inst.rsp_q, 32'h0);
    chk("decrement_branch_nonzero C nz", csb_seq_model_inst.nz_q, 32'h0);
    program_status_word(16'h0000);
    go(csb_pkg::CMD_WR8, 4'h3, 1'b1, 32'h5, '0);
    go(csb_pkg::CMD_DECREMENT_BRANCH_NONZERO, 4'h1, 1'b1, '0, '0);
    chk("decrement_branch_nonzero B nz", csb_seq_model_inst.nz_q, 32'h1);
    go(csb_pkg::CMD_RD8, 4'h3, 1'b0, '0, '0);
    chk("B back", csb_seq_model_inst.rsp_q, 32'h4);
    $display("swap test done");
    // Context switch saves counter and old status word
    p = $urandom();
    p[14:12] = 3'h1;
    program_status_word(p);
    ad = $urandom();
    go(csb_pkg::CMD_CTX, 4'h5, 1'b0, '0, ad);
    chk("ctx bank", bank, 32'h5);
    go(csb_pkg::CMD_RD16, 4'h2, 1'b0, '0, '0);
    chk("ctx lo", csb_seq_model_inst.rsp_q, ad[15:0]);
    go(csb_pkg::CMD_RD16, 4'h3, 1'b0, '0, '0);
    chk("ctx hi", csb_seq_model_inst.rsp_q, {p[15:12], ad[19:16], p[7:0]});
    // Pointers and the wide operand
    b = $urandom_range(3);
    v = $urandom();
    go(csb_pkg::CMD_WR24, 4'(b), 1'b0, {8'h0, v}, '0);
    go(csb_pkg::CMD_RD24, 4'(b), 1'b0, '0, '0);
    chk("ptr24", csb_seq_model_inst.rsp_q, v);
    seed_v = $urandom();
    go(csb_pkg::CMD_WR32, 4'h0, 1'b0, seed_v, '0);
    go(csb_pkg::CMD_RD32, 4'h0, 1'b0, '0, '0);
    chk("quad", csb_seq_model_inst.rsp_q, seed_v);
    go(csb_pkg::CMD_RD16, 4'h6, 1'b0, '0, '0);
    chk("index DE", csb_seq_model_inst.rsp_q, seed_v[15:0]);
    $display("context test done");
    close_out();
  end
endmodule : cpu_stack_and_banked_registers_tb_top

// ### verif/csb_seq_model.sv
/*
  Model of the instruction sequencer that feeds the command port.
  Assumes one core clock; the bench calls issue() one command at a time.
*/
`timescale 1ns/1ns
module csb_seq_model (
  // Clock and answers
  input wire logic i_clock,
  input wire logic i_ready,
  input wire logic i_rsp_valid,
  input wire logic [31:0] i_rsp_data,
  input wire logic i_rsp_nonzero,
  input wire logic i_rsp_miss,
  // Command request
  output logic o_valid,
  output csb_pkg::csb_cmd_e o_cmd,
  output logic [3:0] o_sel,
  output logic o_func,
  output logic [31:0] o_data,
  output logic [19:0] o_addr,
  output logic [19:0] o_pc
);
  logic [31:0] rsp_q;
  logic nz_q;
  logic miss_q;

  // Idle request lines at time zero
  initial begin
    o_valid = 1'b0;
    o_cmd = csb_pkg::CMD_RD8;
    {o_sel, o_func, o_data, o_addr, o_pc} = '0;
  end

  // One request, held until taken, then wait for the answer under a bound
  task automatic issue(input csb_pkg::csb_cmd_e c, input logic [3:0] s, input logic f,
                       input logic [31:0] d, input logic [19:0] a, output logic ok);
    int n;
    @(posedge i_clock);
    #1;
    o_valid = 1'b1;
    o_cmd = c;
    o_sel = s;
    o_func = f;
    o_data = d;
    o_addr = a;
    o_pc = a;
    for (n = 0; n < 8 && i_ready !== 1'b1; n++) @(posedge i_clock) #1;
    @(posedge i_clock);
    #1;
    // Released data, address and pc lines must not keep their last value
    o_valid = 1'b0;
    o_data = ~d;
    o_addr = ~a;
    o_pc = ~a;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_rsp_valid === 1'b1) begin
        ok = 1'b1;
        rsp_q = i_rsp_data;
        nz_q = i_rsp_nonzero;
        miss_q = i_rsp_miss;
      end else begin
        @(posedge i_clock) #1;
      end
    end
  endtask : issue
endmodule : csb_seq_model
